// File: logic/offset_pkg.sv
// How it works
// - Load-select strap picks serial or parallel defaults
// - Serial mode shifts one bit per write edge
// - Full serial sequence is twice offset width
// - Serial offsets commit only after complete sequence
// - Serial enable high blocks serial shifting
// - Paused serial programming resumes at next bit
// - Full flag valid two write edges later
// - No serial readback path exists
// - Parallel writes alternate empty then full offset
// - Master reset homes pointers; partial reset keeps them
// - Load select high diverts writes; pointer kept
// - Parallel write revalidates only that flag
// - Parallel reads alternate empty then full offset
// - Interrupted readback resumes at same pointer
// - Offset read overwrites read data output
// - Readback allowed in both timing modes
// - Retransmit sampled low on read edge
// - Standard mode: empty flag low during setup
// - Fall-through mode: output ready high during setup
// - Half-full updates now, almost-empty two read edges later
// - Almost-full updates two write edges after setup
package offset_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] ADDR_EMPTY_OFS = 8'h00;
    localparam logic [7:0] ADDR_FULL_OFS  = 8'h04;
    localparam logic [7:0] ADDR_STATUS    = 8'h08;

    localparam int ST_SERIAL_MODE = 0;
    localparam int ST_FALL_THRU   = 1;
    localparam int ST_AE_VALID    = 2;
    localparam int ST_AF_VALID    = 3;
    localparam int ST_WR_PTR      = 4;
    localparam int ST_RD_PTR      = 5;
    localparam int ST_RETX_BUSY   = 6;
    localparam int ST_SER_CNT     = 8;

    // ****************************************
    // Reset values and timing
    // ****************************************
    localparam logic [13:0] SERIAL_DEFAULT   = 14'h03FF;
    localparam logic [13:0] PARALLEL_DEFAULT = 14'h007F;
    localparam logic [1:0]  FLAG_EDGES       = 2'h2;

    typedef enum logic [1:0] {
        RT_IDLE  = 2'b01,
        RT_SETUP = 2'b10
    } retx_state_e;

    typedef struct packed {
        logic master_reset_n;
        logic partial_reset_n;
        logic offset_load_select_n;
        logic serial_enable_n;
        logic serial_in;
        logic write_enable_n;
        logic read_enable_n;
        logic retransmit_request_n;
        logic fall_through_mode;
        logic wclk;
        logic rclk;
    } ctrl_pins_s;

endpackage

// File: logic/offset_ctrl.sv
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
module offset_ctrl
    import offset_pkg::*;
#(
    parameter int OFFSET_W = 13,
    parameter int DATA_W   = 18
)
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire ctrl_pins_s        pins,
    input  wire logic [DATA_W-1:0] write_data_bus,
    output logic      [DATA_W-1:0] read_data_bus,
    output logic                   almost_empty_valid,
    output logic                   almost_full_valid,
    output logic                   empty_flag_n,
    output logic                   output_ready_n,
    output logic                   read_ptr_rewind,
    output logic                   first_word_load,
    output logic                   half_full_update,
    output logic                   almost_empty_update,
    output logic                   almost_full_update
);

    localparam int SER_LEN = 2 * OFFSET_W;
    localparam int CNT_W   = $clog2(SER_LEN + 1);
    localparam logic [CNT_W-1:0] SER_LAST = CNT_W'(SER_LEN - 1);

    // ****************************************
    // Pin decode
    // ****************************************
    logic                wclk_q_reg;
    logic                rclk_q_reg;
    logic                serial_mode_reg;
    logic                fall_thru_reg;
    logic [OFFSET_W-1:0] empty_ofs_reg;
    logic [OFFSET_W-1:0] full_ofs_reg;
    logic [SER_LEN-1:0]  stage_reg;
    logic [CNT_W-1:0]    ser_cnt_reg;
    logic                wr_ptr_reg;
    logic                rd_ptr_reg;
    logic                ae_valid_reg;
    logic                af_valid_reg;
    logic [1:0]          ae_wait_reg;
    logic [1:0]          af_wait_reg;
    logic [1:0]          rt_ae_reg;
    logic [1:0]          rt_af_reg;
    retx_state_e         retx_reg;
    logic                pready_reg;

    wire master_reset      = ~pins.master_reset_n;
    wire partial_reset      = ~pins.partial_reset_n;
    wire w_rise   = pins.wclk & ~wclk_q_reg;
    wire r_rise   = pins.rclk & ~rclk_q_reg;
    wire ld_low   = ~pins.offset_load_select_n;
    // shift only while both selects low; count persists across pauses
    wire ser_shift = ~master_reset & serial_mode_reg & ld_low & ~pins.serial_enable_n & w_rise;
    wire ser_done  = ser_shift & (ser_cnt_reg == SER_LAST);
    // parallel write only with load select low
    wire par_wr   = ~master_reset & ~serial_mode_reg & ld_low & ~pins.write_enable_n & w_rise;
    // parallel readback only, either mode, pointer held while paused
    wire par_rd   = ~master_reset & ld_low & ~pins.read_enable_n & r_rise;
    wire rt_setup = ~master_reset & ~partial_reset & (retx_reg == RT_IDLE) & r_rise & ~pins.retransmit_request_n;
    wire rt_done  = (retx_reg == RT_SETUP) & r_rise;

    wire [SER_LEN-1:0] stage_next = {pins.serial_in, stage_reg[SER_LEN-1:1]};

    // ****************************************
    // APB decode
    // ****************************************
    wire apb_setup = psel & ~penable;
    wire apb_wr    = psel & penable & pwrite & pready_reg;
    wire hit_empty = (paddr == ADDR_EMPTY_OFS);
    wire hit_full  = (paddr == ADDR_FULL_OFS);
    wire hit_stat  = (paddr == ADDR_STATUS);
    wire hit_any   = hit_empty | hit_full | hit_stat;
    wire sw_empty  = apb_wr & hit_empty & ~master_reset;
    wire sw_full   = apb_wr & hit_full & ~master_reset;

    wire wr_empty  = (par_wr & ~wr_ptr_reg) | sw_empty;
    wire wr_full   = (par_wr & wr_ptr_reg) | sw_full;

    wire [31:0] status_word = {
        {(32 - ST_SER_CNT - CNT_W){1'b0}}, ser_cnt_reg, 1'b0,
        retx_reg == RT_SETUP, rd_ptr_reg, wr_ptr_reg, af_valid_reg, ae_valid_reg,
        fall_thru_reg, serial_mode_reg
    };
    wire [31:0] rd_mux = hit_empty ? 32'(empty_ofs_reg) :
                         hit_full  ? 32'(full_ofs_reg)  :
                         hit_stat  ? status_word        : 32'h0000_0000;
    wire [OFFSET_W-1:0] rd_ofs = rd_ptr_reg ? full_ofs_reg : empty_ofs_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg <= 1'b0;
            prdata     <= 32'h0000_0000;
            pslverr    <= 1'b0;
        end
        else
        begin
            pready_reg <= apb_setup;
            if (apb_setup)
            begin
                prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr <= ~hit_any;
            end
        end
    end
    assign pready = pready_reg;

    // ****************************************
    // Clock edge sampling and straps
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wclk_q_reg      <= 1'b0;
            rclk_q_reg      <= 1'b0;
            serial_mode_reg <= 1'b0;
            fall_thru_reg   <= 1'b0;
        end
        else
        begin
            wclk_q_reg <= pins.wclk;
            rclk_q_reg <= pins.rclk;
            if (master_reset)
            begin
                serial_mode_reg <= ld_low ? 1'b0 : 1'b1;
                fall_thru_reg   <= pins.fall_through_mode;
            end
        end
    end

    // ****************************************
    // Offset registers and pointers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            empty_ofs_reg <= OFFSET_W'(PARALLEL_DEFAULT);
            full_ofs_reg  <= OFFSET_W'(PARALLEL_DEFAULT);
            stage_reg     <= '0;
            ser_cnt_reg   <= '0;
            wr_ptr_reg    <= 1'b0;
            rd_ptr_reg    <= 1'b0;
        end
        else if (master_reset)
        begin
            empty_ofs_reg <= ld_low ? OFFSET_W'(PARALLEL_DEFAULT) : OFFSET_W'(SERIAL_DEFAULT);
            full_ofs_reg  <= ld_low ? OFFSET_W'(PARALLEL_DEFAULT) : OFFSET_W'(SERIAL_DEFAULT);
            ser_cnt_reg   <= '0;
            wr_ptr_reg    <= 1'b0;
            rd_ptr_reg    <= 1'b0;
        end
        else
        begin
            if (ser_shift)
            begin
                stage_reg   <= stage_next;
                ser_cnt_reg <= ser_done ? '0 : ser_cnt_reg + 1'b1;
            end
            if (ser_done)
            begin
                empty_ofs_reg <= stage_next[OFFSET_W-1:0];
                full_ofs_reg  <= stage_next[SER_LEN-1:OFFSET_W];
            end
            else
            begin
                if (wr_empty)
                    empty_ofs_reg <= sw_empty ? pwdata[OFFSET_W-1:0]
                                              : write_data_bus[OFFSET_W-1:0];
                if (wr_full)
                    full_ofs_reg  <= sw_full ? pwdata[OFFSET_W-1:0]
                                             : write_data_bus[OFFSET_W-1:0];
            end
            if (par_wr)
                wr_ptr_reg <= ~wr_ptr_reg;
            if (par_rd)
                rd_ptr_reg <= ~rd_ptr_reg;
        end
    end

    // ****************************************
    // Partial flag validity
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            af_valid_reg <= 1'b1;
            af_wait_reg  <= 2'h0;
        end
        else if (master_reset)
        begin
            af_valid_reg <= 1'b1;
            af_wait_reg  <= 2'h0;
        end
        else if (ser_done | wr_full)
        begin
            af_valid_reg <= 1'b0;
            af_wait_reg  <= FLAG_EDGES;
        end
        else if (ser_shift)
        begin
            af_valid_reg <= 1'b0;
            af_wait_reg  <= 2'h0;
        end
        else if (w_rise && af_wait_reg != 2'h0)
        begin
            af_wait_reg <= af_wait_reg - 2'h1;
            if (af_wait_reg == 2'h1)
                af_valid_reg <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ae_valid_reg <= 1'b1;
            ae_wait_reg  <= 2'h0;
        end
        else if (master_reset)
        begin
            ae_valid_reg <= 1'b1;
            ae_wait_reg  <= 2'h0;
        end
        else if (ser_done | wr_empty)
        begin
            ae_valid_reg <= 1'b0;
            ae_wait_reg  <= FLAG_EDGES;
        end
        else if (ser_shift)
        begin
            ae_valid_reg <= 1'b0;
            ae_wait_reg  <= 2'h0;
        end
        else if (r_rise && ae_wait_reg != 2'h0)
        begin
            ae_wait_reg <= ae_wait_reg - 2'h1;
            if (ae_wait_reg == 2'h1)
                ae_valid_reg <= 1'b1;
        end
    end

    assign almost_empty_valid = ae_valid_reg;
    assign almost_full_valid  = af_valid_reg;

    // ****************************************
    // Readback output register
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            read_data_bus <= '0;
        else if (master_reset | partial_reset)
            read_data_bus <= '0;
        else if (par_rd)
            read_data_bus <= DATA_W'(rd_ofs);
    end

    // ****************************************
    // Retransmit sequencing
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            retx_reg        <= RT_IDLE;
            empty_flag_n    <= 1'b0;
            output_ready_n  <= 1'b1;
            read_ptr_rewind <= 1'b0;
            first_word_load <= 1'b0;
        end
        else if (master_reset | partial_reset)
        begin
            retx_reg        <= RT_IDLE;
            empty_flag_n    <= 1'b0;
            output_ready_n  <= 1'b1;
            read_ptr_rewind <= 1'b0;
            first_word_load <= 1'b0;
        end
        else
        begin
            read_ptr_rewind <= rt_setup;
            first_word_load <= rt_done & fall_thru_reg;
            unique case (retx_reg)
                RT_IDLE:
                begin
                    if (rt_setup)
                    begin
                        retx_reg <= RT_SETUP;
                        if (fall_thru_reg)
                            output_ready_n <= 1'b1;
                        else
                            empty_flag_n <= 1'b0;
                    end
                end
                RT_SETUP:
                begin
                    if (rt_done)
                    begin
                        retx_reg <= RT_IDLE;
                        if (fall_thru_reg)
                            output_ready_n <= 1'b0;
                        else
                            empty_flag_n <= 1'b1;
                    end
                end
                default:
                    retx_reg <= RT_IDLE;
            endcase
        end
    end

    // Flag update pulses after a retransmit setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rt_ae_reg           <= 2'h0;
            rt_af_reg           <= 2'h0;
            half_full_update    <= 1'b0;
            almost_empty_update <= 1'b0;
            almost_full_update  <= 1'b0;
        end
        else if (master_reset | partial_reset)
        begin
            rt_ae_reg           <= 2'h0;
            rt_af_reg           <= 2'h0;
            half_full_update    <= 1'b0;
            almost_empty_update <= 1'b0;
            almost_full_update  <= 1'b0;
        end
        else
        begin
            half_full_update    <= rt_setup;
            almost_empty_update <= 1'b0;
            almost_full_update  <= 1'b0;
            if (rt_setup)
                rt_ae_reg <= FLAG_EDGES;
            else if (r_rise && rt_ae_reg != 2'h0)
            begin
                rt_ae_reg <= rt_ae_reg - 2'h1;
                almost_empty_update <= (rt_ae_reg == 2'h1);
            end
            if (rt_setup)
                rt_af_reg <= FLAG_EDGES;
            else if (w_rise && rt_af_reg != 2'h0)
            begin
                rt_af_reg <= rt_af_reg - 2'h1;
                almost_full_update <= (rt_af_reg == 2'h1);
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    mode_strap_a: assert property (@(posedge pclk) disable iff (!presetn)
        master_reset |=> serial_mode_reg == !$past(ld_low))
        else $error("load mode strap not captured");

    serial_commit_a: assert property (@(posedge pclk) disable iff (!presetn)
        ser_done |=> ser_cnt_reg == '0 && !af_valid_reg && !ae_valid_reg)
        else $error("serial sequence did not close");

    no_partial_update_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ser_shift && !ser_done && !apb_wr) |=> $stable(empty_ofs_reg) && $stable(full_ofs_reg))
        else $error("offset changed mid serial sequence");

    af_valid_time_a: assert property (@(posedge pclk) disable iff (!presetn)
        ($rose(af_valid_reg) && !$past(master_reset)) |-> $past(w_rise) && $past(af_wait_reg) == 2'h1)
        else $error("almost full validity timing wrong");

    serial_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        (serial_mode_reg && ld_low && pins.serial_enable_n && !master_reset && !apb_wr)
        |=> $stable(empty_ofs_reg) && $stable(full_ofs_reg) && $stable(ser_cnt_reg))
        else $error("serial write while serial enable high");

    write_ptr_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        par_wr |=> wr_ptr_reg != $past(wr_ptr_reg))
        else $error("write offset pointer did not advance");

    readback_data_a: assert property (@(posedge pclk) disable iff (!presetn)
        par_rd |=> read_data_bus == DATA_W'($past(rd_ofs)) && rd_ptr_reg != $past(rd_ptr_reg))
        else $error("offset readback wrong");

    ptr_home_a: assert property (@(posedge pclk) disable iff (!presetn)
        master_reset |=> !wr_ptr_reg && !rd_ptr_reg)
        else $error("pointers not homed by master reset");

    retx_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        rt_setup |=> retx_reg == RT_SETUP && half_full_update && read_ptr_rewind)
        else $error("retransmit setup not started");

    retx_empty_a: assert property (@(posedge pclk) disable iff (!presetn)
        (retx_reg == RT_SETUP && !fall_thru_reg) |-> !empty_flag_n)
        else $error("empty flag high during setup");

endmodule

// File: tb/far_ctrl.sv
`timescale 1ns/100ps
module far_ctrl
    import offset_pkg::*;
(
    input  wire logic pclk,
    output ctrl_pins_s pins
);
    // ****************************************
    // Controlling logic on the FIFO ports
    // ****************************************
    initial
    begin
        pins = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    end

    // Never mixes an offset read with an offset write
    task automatic set_lines(input logic ld_n, input logic sen_n, input logic wen_n,
                             input logic ren_n);
        @(posedge pclk);
        pins.offset_load_select_n <= ld_n;
        pins.serial_enable_n      <= sen_n;
        pins.write_enable_n       <= wen_n;
        pins.read_enable_n        <= ren_n;
        @(negedge pclk);
    endtask

    // One bit or word per write clock rise
    task automatic wtick(input logic si);
        @(posedge pclk);
        pins.serial_in <= si;
        pins.wclk      <= 1'b1;
        @(posedge pclk);
        pins.serial_in <= ~si;
        pins.wclk      <= 1'b0;
        @(negedge pclk);
    endtask

    task automatic rtick;
        @(posedge pclk);
        pins.rclk <= 1'b1;
        @(posedge pclk);
        pins.rclk <= 1'b0;
        @(negedge pclk);
    endtask

    task automatic mreset(input logic ld_n, input logic ft);
        @(posedge pclk);
        pins.master_reset_n       <= 1'b0;
        pins.offset_load_select_n <= ld_n;
        pins.fall_through_mode    <= ft;
        repeat (2) @(posedge pclk);
        pins.master_reset_n       <= 1'b1;
        @(posedge pclk);
        pins.offset_load_select_n <= 1'b1;
        pins.fall_through_mode    <= ~ft;
        @(negedge pclk);
    endtask

    task automatic preset;
        @(posedge pclk);
        pins.partial_reset_n <= 1'b0;
        @(posedge pclk);
        pins.partial_reset_n <= 1'b1;
        @(negedge pclk);
    endtask

    // One memory word before retransmit
    task automatic write_word;
        set_lines(1'b1, 1'b1, 1'b0, 1'b1);
        wtick(1'b0);
    endtask

    // Enables high before the request
    task automatic retx;
        set_lines(1'b1, 1'b1, 1'b1, 1'b1);
        @(posedge pclk);
        pins.retransmit_request_n <= 1'b0;
        pins.rclk                 <= 1'b1;
        @(posedge pclk);
        pins.retransmit_request_n <= 1'b1;
        pins.rclk                 <= 1'b0;
        @(negedge pclk);
    endtask
endmodule

// File: tb/testbench.sv
`timescale 1ns/100ps
module testbench;
    import offset_pkg::*;
    // ****************************************
    // Bench state
    // ****************************************
    logic        pclk = 1'b0;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    ctrl_pins_s  pins;
    logic [17:0] write_data_bus;
    logic [17:0] read_data_bus;
    logic        ae_v, af_v, ef_n, or_n, rew, fwl, hfu, aeu, afu;
    logic [31:0] rd;
    logic        err, b;
    int          bad_count = 0, comparisons = 0, cycles = 0, seed = 32'h1629;
    int          e, f, wp, rp, i, n_rew = 0, n_fwl = 0, n_hf = 0, n_ae = 0, n_af = 0;

    always #12.5 pclk = ~pclk;

    far_ctrl far_ctrl_inst (.pclk(pclk), .pins(pins));

    offset_ctrl offset_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
        .write_data_bus(write_data_bus), .read_data_bus(read_data_bus),
        .almost_empty_valid(ae_v), .almost_full_valid(af_v), .empty_flag_n(ef_n),
        .output_ready_n(or_n), .read_ptr_rewind(rew), .first_word_load(fwl),
        .half_full_update(hfu), .almost_empty_update(aeu), .almost_full_update(afu));

    task automatic finish_test;
        $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20)
            bad_count++;
    endtask

    task automatic offsets;
        apb(1'b0, ADDR_EMPTY_OFS, 32'h0);
        check(rd, e);
        apb(1'b0, ADDR_FULL_OFS, 32'h0);
        check(rd, f);
    endtask

    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        n_rew <= n_rew + (rew === 1'b1);
        n_fwl <= n_fwl + (fwl === 1'b1);
        n_hf <= n_hf + (hfu === 1'b1);
        n_ae <= n_ae + (aeu === 1'b1);
        n_af <= n_af + (afu === 1'b1);
        if (cycles > 20000)
        begin
            bad_count++;
            finish_test;
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial
    begin
        presetn        <= 1'b0;
        psel           <= 1'b0;
        penable        <= 1'b0;
        pwrite         <= 1'b0;
        paddr          <= 8'h00;
        pwdata         <= 32'h0000_0000;
        write_data_bus <= 18'h00000;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        far_ctrl_inst.mreset(1'b1, 1'b0);
        e = 32'h3FF;
        f = 32'h3FF;
        offsets();
        far_ctrl_inst.set_lines(1'b0, 1'b0, 1'b1, 1'b1);
        for (i = 0; i < 26; i++)
        begin
            b = $random(seed);
            if (i == 9)
            begin
                far_ctrl_inst.set_lines(1'b0, 1'b1, 1'b1, 1'b1);
                repeat (3) far_ctrl_inst.wtick(~b);
                far_ctrl_inst.set_lines(1'b0, 1'b0, 1'b1, 1'b1);
            end
            if (i == 25)
                offsets();
            far_ctrl_inst.wtick(b);
            if (i == 0)
                check(af_v, 1'b0);
            if (i < 13)
                wp = (i == 0 ? 0 : wp) | (int'(b) << i);
            else
                rp = (i == 13 ? 0 : rp) | (int'(b) << (i - 13));
        end
        e = wp;
        f = rp;
        far_ctrl_inst.set_lines(1'b1, 1'b1, 1'b1, 1'b1);
        far_ctrl_inst.wtick(1'b0);
        check(af_v, 1'b0);
        far_ctrl_inst.wtick(1'b0);
        check(af_v, 1'b1);
        repeat (2) far_ctrl_inst.rtick();
        check(ae_v, 1'b1);
        offsets();
        write_data_bus <= 18'h00015;
        far_ctrl_inst.set_lines(1'b0, 1'b1, 1'b0, 1'b1);
        far_ctrl_inst.wtick(1'b0);
        far_ctrl_inst.set_lines(1'b0, 1'b1, 1'b1, 1'b0);
        far_ctrl_inst.rtick();
        check(read_data_bus, e);
        far_ctrl_inst.mreset(1'b0, 1'b0);
        e = 32'h7F;
        f = 32'h7F;
        wp = 0;
        rp = 0;
        far_ctrl_inst.set_lines(1'b0, 1'b1, 1'b0, 1'b1);
        for (i = 0; i < 4; i++)
        begin
            if (i == 1)
            begin
                far_ctrl_inst.set_lines(1'b1, 1'b1, 1'b0, 1'b1);
                far_ctrl_inst.wtick(1'b0);
                far_ctrl_inst.set_lines(1'b0, 1'b1, 1'b0, 1'b1);
            end
            @(posedge pclk);
            write_data_bus <= 18'($random(seed) & 32'h1FFF);
            @(negedge pclk);
            if (wp == 0)
                e = write_data_bus;
            else
                f = write_data_bus;
            wp = 1 - wp;
            far_ctrl_inst.wtick(1'b0);
            if (i == 0)
                check({ae_v, af_v}, 2'b01);
        end
        offsets();
        far_ctrl_inst.set_lines(1'b0, 1'b1, 1'b1, 1'b0);
        for (i = 0; i < 6; i++)
        begin
            if (i == 2)
            begin
                far_ctrl_inst.set_lines(1'b1, 1'b1, 1'b1, 1'b0);
                far_ctrl_inst.rtick();
                far_ctrl_inst.set_lines(1'b0, 1'b1, 1'b1, 1'b0);
            end
            if (i == 4)
                far_ctrl_inst.preset();
            far_ctrl_inst.rtick();
            check(read_data_bus, rp ? f : e);
            rp = 1 - rp;
        end
        apb(1'b1, ADDR_EMPTY_OFS, 32'($random(seed)) & 32'h1FFF);
        e = pwdata;
        apb(1'b0, 8'h0C, 32'h0);
        check({31'h0, err}, 32'h1);
        offsets();
        far_ctrl_inst.write_word();
        far_ctrl_inst.retx();
        check(ef_n, 1'b0);
        check({rew, hfu}, 2'b11);
        far_ctrl_inst.rtick();
        check(n_rew + n_hf, 2);
        check({ef_n, 31'(n_ae)}, 32'h80000000);
        far_ctrl_inst.rtick();
        check(aeu, 1'b1);
        far_ctrl_inst.wtick(1'b0);
        check(n_ae + n_af, 1);
        far_ctrl_inst.wtick(1'b0);
        check(afu, 1'b1);
        far_ctrl_inst.write_word();
        far_ctrl_inst.retx();
        check({ef_n, 31'(n_af)}, 32'h1);
        far_ctrl_inst.mreset(1'b0, 1'b1);
        far_ctrl_inst.write_word();
        far_ctrl_inst.retx();
        check(or_n, 1'b1);
        far_ctrl_inst.rtick();
        check({or_n, 31'(fwl)}, 32'h1);
        far_ctrl_inst.set_lines(1'b0, 1'b1, 1'b1, 1'b0);
        far_ctrl_inst.rtick();
        check(read_data_bus, 32'h7F);
        check(n_fwl, 1);
        finish_test();
    end
endmodule
